// [sac_top.sv]
// Converter control, result buffering and serial readout shift register
`timescale 1ns/1ps
`default_nettype none
module sac_top #(
	parameter int CONV_CYCLES = sac_pkg::CONV_CYC,
	parameter int WAKE_CYCLES = sac_pkg::WAKE_CYC,
	parameter bit BIPOLAR = 1'b1,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Host pins
	input wire logic convert_start_n_i,
	input wire logic serial_clock_i,
	output logic busy_o,
	output logic serial_result_out_o,
	output logic serial_result_out_oe_o,
	// Analog front end
	input wire logic [11:0] sample_code_i,
	output logic hold_o,
	output logic power_down_o
);
	localparam int W = sac_pkg::RES_W;
	sac_if #(.W(W)) conv_if ();
	localparam int NPIN = 2;
	localparam int PIN_CS = 0;
	localparam int PIN_SC = 1;
	// Idle levels: start pin rests high, serial clock rests low
	localparam logic [1:0] PIN_IDLE = 2'b01;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_m_q;
	logic [NPIN-1:0] pin_s_q;
	logic [NPIN-1:0] pin_p_q;
	logic [NPIN-1:0] pin_fall;
	logic [NPIN-1:0] pin_rise;
	logic cs_s_q, sc_s_q;
	logic cs_fall, cs_rise, sc_fall, sc_rise;
	logic wake_done;
	logic capture_now;
	logic frame_start, frame_end, frame_clear;

	sac_pkg::sac_state_e state_q;
	logic [15:0] cnt_q;
	logic [11:0] code_q;
	logic done;
	logic f_valid, f_ready;
	logic [11:0] f_data;
	logic [11:0] out_reg_q;
	logic [15:0] shift_q;
	logic [4:0] bit_q;
	logic sc_armed_q;

	// Edge decode on a pair of synchronised samples
	function automatic logic edge_seen(input logic prev, input logic now, input logic rising);
		edge_seen = rising ? (!prev && now) : (prev && !now);
	endfunction : edge_seen

	// Conversion running and not on its last cycle
	function automatic logic conv_active(input sac_pkg::sac_state_e st, input logic fin);
		conv_active = (st == sac_pkg::SAC_ST_CONV) && !fin;
	endfunction : conv_active

	// Readout frame: leading zeros, then result MSB first
	function automatic logic [15:0] frame_word(input logic [11:0] code);
		frame_word = {{sac_pkg::LEAD_ZEROS{1'b0}}, code};
	endfunction : frame_word

	// Bipolar ranges flip the MSB into two's complement
	function automatic logic [11:0] fmt_code(input logic [11:0] raw, input logic bip);
		fmt_code = bip ? (raw ^ sac_pkg::MID_CODE) : raw;
	endfunction : fmt_code

	// Pin order inside the synchroniser bank
	assign pin_raw = {serial_clock_i, convert_start_n_i};

	// Two flip-flops per pin before any logic, third keeps edge history
	for (genvar g = 0; g < NPIN; g++)
	begin : g_sync
		always_ff @(posedge clock_i)
		begin
			if (rst_i)
			begin
				pin_m_q[g] <= PIN_IDLE[g];
				pin_s_q[g] <= PIN_IDLE[g];
				pin_p_q[g] <= PIN_IDLE[g];
			end
			else
			begin
				pin_m_q[g] <= pin_raw[g];
				pin_s_q[g] <= pin_m_q[g];
				pin_p_q[g] <= pin_s_q[g];
			end
		end
		// Edge flags, one cycle each
		assign pin_fall[g] = edge_seen(pin_p_q[g], pin_s_q[g], 1'b0);
		assign pin_rise[g] = edge_seen(pin_p_q[g], pin_s_q[g], 1'b1);
	end

	// Named views of the synchronised pins
	assign cs_s_q = pin_s_q[PIN_CS];
	assign sc_s_q = pin_s_q[PIN_SC];
	assign cs_fall = pin_fall[PIN_CS];
	assign cs_rise = pin_rise[PIN_CS];
	assign sc_fall = pin_fall[PIN_SC];
	assign sc_rise = pin_rise[PIN_SC];

	// Wake time reached after a sleep-mode rising edge
	assign wake_done = (cnt_q >= 16'(WAKE_CYCLES - 1));

	// Conversion sequencer state
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			state_q <= sac_pkg::SAC_ST_TRACK;
		else
		begin
			case (state_q)
				sac_pkg::SAC_ST_TRACK:
				begin
					if (cs_fall)
						state_q <= sac_pkg::SAC_ST_CONV;
				end
				sac_pkg::SAC_ST_CONV:
				begin
					// Start pin still low at the end selects auto sleep
					if (done && !cs_s_q)
						state_q <= sac_pkg::SAC_ST_SLEEP;
					else if (done)
						state_q <= sac_pkg::SAC_ST_TRACK;
				end
				sac_pkg::SAC_ST_SLEEP:
				begin
					if (cs_rise)
						state_q <= sac_pkg::SAC_ST_WAKE;
				end
				sac_pkg::SAC_ST_WAKE:
				begin
					// Hold only once awake and with the start pin low
					if (wake_done && !cs_s_q)
						state_q <= sac_pkg::SAC_ST_CONV;
				end
				default:
					state_q <= sac_pkg::SAC_ST_TRACK;
			endcase
		end
	end

	// Cycle counter on the internal clock, cleared on every state change
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			cnt_q <= '0;
		else
		begin
			case (state_q)
				sac_pkg::SAC_ST_TRACK:
					cnt_q <= '0;
				sac_pkg::SAC_ST_CONV:
				begin
					if (done)
						cnt_q <= '0;
					else
						cnt_q <= cnt_q + 16'h0001;
				end
				sac_pkg::SAC_ST_SLEEP:
					cnt_q <= '0;
				sac_pkg::SAC_ST_WAKE:
				begin
					if (wake_done && !cs_s_q)
						cnt_q <= '0;
					else if (!wake_done)
						cnt_q <= cnt_q + 16'h0001;
				end
				default:
					cnt_q <= '0;
			endcase
		end
	end

	// Last conversion cycle; stretches while the FIFO has no room
	assign done = (state_q == sac_pkg::SAC_ST_CONV) && (cnt_q >= 16'(CONV_CYCLES - 1))
		&& conv_if.ready;

	// Busy pin, high for the whole conversion
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			busy_o <= 1'b0;
		else
			busy_o <= conv_active(state_q, done);
	end

	// Track/hold in hold for the conversion, tracking again at its end
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			hold_o <= 1'b0;
		else
			hold_o <= conv_active(state_q, done);
	end

	// Power-down flag while asleep
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			power_down_o <= 1'b0;
		else
			power_down_o <= (state_q == sac_pkg::SAC_ST_SLEEP);
	end

	// Sample taken at the start edge, or while waiting in wake with start low
	assign capture_now = (state_q == sac_pkg::SAC_ST_TRACK && cs_fall)
		|| (state_q == sac_pkg::SAC_ST_WAKE && !cs_s_q);

	// Capture sample at hold, format code
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			code_q <= sac_pkg::RESULT_RST;
		else if (capture_now)
			code_q <= fmt_code(sample_code_i, BIPOLAR);
	end

	// Result stream into FIFO at end of conversion
	assign conv_if.valid = done;
	assign conv_if.data = code_q;

	sac_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.in_if(conv_if),
		.out_valid_o(f_valid),
		.out_ready_i(f_ready),
		.out_data_o(f_data)
	);

	// Output register takes newest word; drains whole FIFO
	assign f_ready = 1'b1;
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			out_reg_q <= sac_pkg::RESULT_RST;
		else if (f_valid)
			out_reg_q <= f_data;
	end

	// Frame start: rising serial clock with no frame open, also after extra clocks
	assign frame_start = sc_rise && bit_q == 5'd0 && !sc_armed_q;
	// Frame end: sixteenth falling serial clock
	assign frame_end = sc_fall && sc_armed_q && bit_q == 5'(sac_pkg::FRAME_BITS - 1);
	// Start pin falling with the serial clock low clears the readout
	assign frame_clear = cs_fall && !sc_s_q;

	// Bit counter
	always_ff @(posedge clock_i)
	begin
		if (rst_i || frame_clear)
			bit_q <= '0;
		else if (frame_end)
			bit_q <= '0;
		else if (sc_fall && sc_armed_q)
			bit_q <= bit_q + 5'd1;
	end

	// Frame open flag, drives the output enable
	always_ff @(posedge clock_i)
	begin
		if (rst_i || frame_clear)
			sc_armed_q <= 1'b0;
		else if (frame_start)
			sc_armed_q <= 1'b1;
		else if (frame_end)
			sc_armed_q <= 1'b0;
	end

	// Output shift register, loaded at frame start
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			shift_q <= '0;
		else if (frame_start)
			shift_q <= frame_word(out_reg_q);
		else if (sc_fall && sc_armed_q && !frame_end)
			shift_q <= {shift_q[14:0], 1'b0};
	end

	// Serial data pin, floats outside a frame
	assign serial_result_out_o = shift_q[15];
	assign serial_result_out_oe_o = sc_armed_q;
endmodule : sac_top
`default_nettype wire

// [sac_pkg.sv]
// Package of constants for the converter control and serial readout block
package sac_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int CONV_NS = 3800;
	localparam int WAKE_NS = 6000;
	localparam int APERTURE_NS = 15;
	localparam int CONV_CYC = (CONV_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int WAKE_CYC = (WAKE_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int APERTURE_CYC = ((APERTURE_NS * (CLK_HZ / 1000000) + 999) / 1000 < 1) ? 1 :
		(APERTURE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int RES_W = 12;
	localparam int FRAME_BITS = 16;
	localparam int LEAD_ZEROS = 4;
	localparam logic [11:0] MID_CODE = 12'h800;
	localparam logic [11:0] RESULT_RST = 12'h000;
	typedef enum logic [2:0] {
		SAC_ST_TRACK = 3'b000,
		SAC_ST_CONV = 3'b001,
		SAC_ST_SLEEP = 3'b011,
		SAC_ST_WAKE = 3'b010
	} sac_state_e;
endpackage : sac_pkg

// [sac_if.sv]
// Stream carrier between the converter control and the result FIFO
`timescale 1ns/1ps
`default_nettype none
interface sac_if #(parameter int W = 12);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sac_if
`default_nettype wire

// [sac_fifo.sv]
// Small synchronous FIFO for conversion results
`timescale 1ns/1ps
`default_nettype none
module sac_fifo #(
	parameter int W = 12,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Fill side
	sac_if.snk in_if,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_q, rd_q;
	logic full, empty;
	// Pointer compare
	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign in_if.ready = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_q[AW-1:0]];
	// Write side
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			wr_q <= '0;
		else if (in_if.valid && !full)
		begin
			mem[wr_q[AW-1:0]] <= in_if.data;
			wr_q <= wr_q + 1'b1;
		end
	end
	// Read side
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			rd_q <= '0;
		else if (out_ready_i && !empty)
			rd_q <= rd_q + 1'b1;
	end
endmodule : sac_fifo
`default_nettype wire

// [sac_asserts.sv]
// Checker for converter control and serial readout
`timescale 1ns/1ps
`default_nettype none
module sac_asserts #(parameter int CONV_CYCLES = 76, parameter int WAKE_CYCLES = 120) (
	// Watched pins
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic convert_start_n_i,
	input wire logic serial_clock_i,
	input wire logic busy_o,
	input wire logic serial_result_out_o,
	input wire logic serial_result_out_oe_o,
	input wire logic hold_o,
	input wire logic power_down_o
);
	localparam int WHI = WAKE_CYCLES + 8;
	logic slept_q;
	logic [7:0] cnt_q;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Marks a conversion woken from sleep
	always_ff @(posedge clock_i)
		slept_q <= !rst_i && (power_down_o || (slept_q && !$fell(busy_o)));
	// Counts busy cycles
	always_ff @(posedge clock_i)
		cnt_q <= (rst_i || !busy_o) ? 8'h00 : cnt_q + 8'h01;
	sequence conv_s; busy_o && hold_o; endsequence
	hold_busy_a: assert property (hold_o |-> busy_o) else $error("hold without busy");
	start_conv_a: assert property ($fell(convert_start_n_i) && !busy_o && !slept_q |-> ##[2:6] conv_s)
		else $error("start missed");
	busy_len_a: assert property ($fell(busy_o) && !slept_q |-> cnt_q inside {[CONV_CYCLES-2:CONV_CYCLES+2]})
		else $error("bad conversion time");
	track_end_a: assert property ($fell(busy_o) |-> $fell(hold_o)) else $error("hold kept");
	sleep_in_a: assert property ($fell(busy_o) && !convert_start_n_i |-> ##[0:4] power_down_o)
		else $error("no sleep");
	wake_hold_a: assert property ($rose(convert_start_n_i) && power_down_o |-> ##[WAKE_CYCLES:WHI] conv_s)
		else $error("bad wake time");
	oe_on_a: assert property ($rose(serial_clock_i) && !serial_result_out_oe_o && !busy_o |-> ##[2:6] serial_result_out_oe_o)
		else $error("output not driven");
	lead_zero_a: assert property ($rose(serial_result_out_oe_o) |-> !serial_result_out_o) else $error("no zero");
endmodule : sac_asserts
bind sac_top sac_asserts #(.CONV_CYCLES(CONV_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) i_chk (.*);
`default_nettype wire

// [sac_host.sv]
// Host model driving start and serial clock
`timescale 1ns/1ps
`default_nettype none
module sac_host (
	// Result pins
	input wire logic sdo_i,
	input wire logic oe_i,
	input wire logic sdo_u_i,
	input wire logic oe_u_i,
	// Host drives
	output logic cs_n_o,
	output logic sclk_o
);
	// Released line shows the inverse bit
	wire logic line_w = oe_i ? sdo_i : ~sdo_i;
	wire logic line_u_w = oe_u_i ? sdo_u_i : ~sdo_u_i;
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
	end
	// n clocks of 400 ns, bit taken before each fall
	task automatic read(input int n, output logic [31:0] v, output logic [31:0] vu);
		v = 32'h0;
		vu = 32'h0;
		repeat (n)
		begin
			sclk_o = 1'b1;
			#200;
			v = {v[30:0], line_w};
			vu = {vu[30:0], line_u_w};
			sclk_o = 1'b0;
			#200;
		end
	endtask : read
endmodule : sac_host
`default_nettype wire

// [testbench.sv]
// Bench for converter control and serial readout
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] sample_code_i = 12'h000;
	wire logic convert_start_n_i, serial_clock_i, busy_o, serial_result_out_o, serial_result_out_oe_o, hold_o, power_down_o;
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	logic [31:0] v;
	logic [31:0] vu;
	wire logic sdo_u, oe_u;
	sac_top i_dut (.*);
	sac_top #(.BIPOLAR(1'b0)) i_dut_uni (.clock_i(clock_i), .rst_i(rst_i), .convert_start_n_i(convert_start_n_i),
		.serial_clock_i(serial_clock_i), .busy_o(), .serial_result_out_o(sdo_u), .serial_result_out_oe_o(oe_u),
		.sample_code_i(sample_code_i), .hold_o(), .power_down_o());
	sac_host i_host (.sdo_i(serial_result_out_o), .oe_i(serial_result_out_oe_o), .sdo_u_i(sdo_u), .oe_u_i(oe_u),
		.cs_n_o(convert_start_n_i), .sclk_o(serial_clock_i));
	// Clock
	initial
		forever #25 clock_i = ~clock_i;
	// Compare and count
	task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", w, e, s);
		end
	endtask : check
	// Bounded wait for a busy level
	task automatic till(input logic b);
		n = 0;
		while (busy_o !== b && n < 400)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		#2;
	endtask : till
	// Start pin and code just after an edge
	task automatic pin(input logic p, input logic [11:0] c);
		@(posedge clock_i);
		#2;
		sample_code_i = c;
		i_host.cs_n_o = p;
	endtask : pin
	// Short start pulse, conversion, read of k bits
	task automatic conv_read(input logic [11:0] c, input int k);
		pin(1'b0, c);
		till(1'b1);
		pin(1'b1, c);
		till(1'b0);
		check("busy time", n >= 72 && n <= 78, 1);
		check("tracking", hold_o, 1'b0);
		i_host.read(k, v, vu);
		#300;
	endtask : conv_read
	// Range ends and midscale coding
	task automatic t_codes;
		logic [11:0] c[5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h5a3};
		foreach (c[i])
		begin
			conv_read(c[i], 16);
			check("frame", v, {20'h00000, c[i] ^ 12'h800});
			check("frame uni", vu, {20'h00000, c[i]});
			check("released", serial_result_out_oe_o, 1'b0);
		end
	endtask : t_codes
	// Extra clocks, then restart by convert start
	task automatic t_extra;
		conv_read(12'h123, 20);
		check("extra", v, {16'h0000, 12'h923, 4'h0});
		check("driven", serial_result_out_oe_o, 1'b1);
		conv_read(12'h456, 16);
		check("restart", v, {20'h00000, 12'hc56});
	endtask : t_extra
	// Auto sleep, read in sleep, timed wake
	task automatic t_sleep;
		int t;
		pin(1'b0, 12'h0f0);
		till(1'b1);
		till(1'b0);
		#302;
		check("sleep", power_down_o, 1'b1);
		i_host.read(16, v, vu);
		check("sleep read", v, {20'h00000, 12'h8f0});
		#300;
		pin(1'b1, 12'h0f0);
		repeat (20) @(posedge clock_i);
		pin(1'b0, 12'h0f0);
		till(1'b1);
		t = 21 + n;
		till(1'b0);
		t = t + n;
		check("wake time", t >= 192 && t <= 206, 1);
	endtask : t_sleep
	// Verdict and end of run
	task automatic close_out;
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clock_i);
		#2;
		rst_i = 1'b0;
		t_codes();
		t_extra();
		t_sleep();
		close_out();
	end
	// Watchdog
	initial
	begin
		#300000;
		num_errors++;
		close_out();
	end
endmodule : testbench
`default_nettype wire
